/* File: logic/pllctl_pkg.sv */
`default_nettype none
package pllctl_pkg;

   // System clock rate and the drift step of a free-running oscillator.
   localparam int CLK_FREQ_MHZ   = 50;
   localparam int DRIFT_STEP_US  = 25;
   localparam int DRIFT_STEP_CYC = DRIFT_STEP_US * CLK_FREQ_MHZ;

   localparam int OSC_W   = 12;
   localparam int DIV_W   = 6;
   localparam int EDGE_W  = 8;
   localparam int DRIFT_W = 11;
   localparam int RUN_W   = 4;

   localparam logic [DRIFT_W-1:0] DRIFT_LAST = DRIFT_W'(DRIFT_STEP_CYC - 1);

   // Oscillator half period in system clocks; the nominal value is the fastest.
   localparam logic [OSC_W-1:0]  OSC_NOMINAL_HALF = 12'h001;
   localparam logic [OSC_W-1:0]  OSC_MIN_HALF     = 12'h001;
   localparam logic [OSC_W-1:0]  OSC_MAX_HALF     = 12'hfff;
   localparam logic [OSC_W-1:0]  OSC_STEP         = 12'h001;
   localparam logic [OSC_W-1:0]  OSC_CNT_ZERO     = 12'h000;

   // Feedback multiplier and reference divider.
   localparam logic [EDGE_W-1:0] FB_MULT    = 8'h04;
   localparam logic [EDGE_W-1:0] EDGE_ONE   = 8'h01;
   localparam logic [EDGE_W-1:0] EDGE_MAX   = 8'hff;
   localparam logic [DIV_W-1:0]  REF_DIV    = 6'h01;
   localparam logic [DIV_W-1:0]  DIV_ONE    = 6'h01;
   localparam logic [DIV_W-1:0]  DIV_ZERO   = 6'h00;
   localparam logic [RUN_W-1:0]  LOCK_RUN_LAST = 4'h7;
   localparam logic [RUN_W-1:0]  RUN_ONE    = 4'h1;
   localparam logic [DRIFT_W-1:0] DRIFT_ONE = 11'h001;

   // Post-scale counters: high and low time in oscillator cycles, initial phase.
   localparam logic [DIV_W-1:0]  G0_HIGH = 6'h01;
   localparam logic [DIV_W-1:0]  G0_LOW  = 6'h01;
   localparam logic [DIV_W-1:0]  G1_HIGH = 6'h02;
   localparam logic [DIV_W-1:0]  G1_LOW  = 6'h02;
   localparam logic [DIV_W-1:0]  E_HIGH  = 6'h01;
   localparam logic [DIV_W-1:0]  E_LOW   = 6'h01;
   localparam logic [DIV_W-1:0]  PH_G0   = 6'h00;
   localparam logic [DIV_W-1:0]  PH_G1   = 6'h00;
   localparam logic [DIV_W-1:0]  PH_E    = 6'h00;

   // Alignment offsets in oscillator cycles for the feedback modes.
   localparam logic [DIV_W-1:0]  ZERO_OFS   = 6'h00;
   localparam logic [DIV_W-1:0]  SKEW_OFS   = 6'h01;
   localparam logic [DIV_W-1:0]  NOCOMP_OFS = 6'h01;

   typedef enum logic [1:0] {
      PLLCTL_FB_NORMAL = 2'b00,
      PLLCTL_FB_ZDB    = 2'b01,
      PLLCTL_FB_NOCOMP = 2'b11
   } pllctl_fb_e;

   typedef enum logic [1:0] {
      PLLCTL_OFF  = 2'b00,
      PLLCTL_ACQ  = 2'b01,
      PLLCTL_LOCK = 2'b11,
      PLLCTL_HOLD = 2'b10
   } pllctl_state_e;

   typedef struct packed {
      logic [1:0]          ena_s;
      logic [1:0]          rst_s;
      logic [1:0]          pfd_s;
      logic [1:0]          rp_s;
      logic [1:0]          rn_s;
      logic                ref_prev;
      pllctl_state_e       st;
      logic [OSC_W-1:0]    half;
      logic [OSC_W-1:0]    osc_cnt;
      logic                osc;
      logic [EDGE_W-1:0]   edges;
      logic [DIV_W-1:0]    refdiv;
      logic [RUN_W-1:0]    run;
      logic [DRIFT_W-1:0]  drift;
      logic                resync;
      logic                out0;
      logic                out1;
      logic                ext_p;
      logic                ext_n;
      logic                ext_p_oe;
      logic                ext_n_oe;
      logic                locked;
   } pllctl_loop_s;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             lvl;
      logic             arm;
      logic             run;
   } pllctl_div_s;

endpackage
`default_nettype wire

/* File: logic/pllctl_postdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module pllctl_postdiv (
   input  wire logic                         clk_i,
   input  wire logic                         sys_rst_i,
   input  wire logic                         clear_i,
   input  wire logic                         load_i,
   input  wire logic                         tick_i,
   input  wire logic [pllctl_pkg::DIV_W-1:0] delay_i,
   input  wire logic [pllctl_pkg::DIV_W-1:0] high_i,
   input  wire logic [pllctl_pkg::DIV_W-1:0] low_i,
   output logic                              level_o
);

   pllctl_pkg::pllctl_div_s q;
   pllctl_pkg::pllctl_div_s next_q;

   always_comb begin
      next_q = q;
      if (clear_i) begin
         next_q = '0;
      end else if (load_i) begin
         // The initial count delays the first high phase to set the output phase.
         next_q.cnt = delay_i;
         next_q.lvl = 1'b0;
         next_q.arm = 1'b1;
         next_q.run = 1'b1;
      end else if (tick_i && q.run) begin
         if (q.cnt != pllctl_pkg::DIV_ZERO) begin
            next_q.cnt = q.cnt - pllctl_pkg::DIV_ONE;
         end else if (q.arm) begin
            next_q.arm = 1'b0;
            next_q.lvl = 1'b1;
            next_q.cnt = high_i - pllctl_pkg::DIV_ONE;
         end else begin
            next_q.lvl = ~q.lvl;
            next_q.cnt = q.lvl ? low_i - pllctl_pkg::DIV_ONE : high_i - pllctl_pkg::DIV_ONE;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign level_o = q.lvl;

endmodule
`default_nettype wire

/* File: logic/pllctl_top.sv */
// Notes on behaviour
// R01: Enable low forces clocks low, lock lost.
// R02: Enable high again relocks and resynchronises outputs.
// R03: Enable may come from logic or pins.
// R04: Unused enable port is tied high internally.
// R05: Loop reset clears counters, output, lock, oscillator.
// R06: Loop reset release resynchronises to reference clock.
// R07: Fast nominal oscillator starts output above target.
// R08: Unused loop reset port is tied low.
// R09: Detector off holds frequency, drifting slowly lower.
// R10: Detector off keeps clocks toggling without reference; clocks only start on a reference edge with the detector on.
// R11: Detector enable reasserted relocks and resynchronises.
// R12: Unused detector enable port is tied high.
// R13: Lock high only when stable and in phase.
// R14: Lock may toggle while tracking begins.
// R15: Three feedback modes only, no external feedback.
// R16: All modes keep multiply, divide, phase, duty.
// R17: Normal mode aligns internal clocks to reference.
// R18: Normal mode offsets external and pin-routed clocks.
// R19: Zero delay mode aligns external pin, offsets internal.
// R20: No compensation offsets all; internal clocks mutually aligned.
// R21: External counter drives pin pair, else pins are GPIO.
// R22: First pin pair feeds first loop, second second.
// R23: External counter output never feeds internal logic.
// R24: Lock drops on disable or reset until relocked.
// R25: Lock consumers should qualify it before releasing resets.
`timescale 1ns/1ps
`default_nettype none
module pllctl_top #(
   parameter logic [1:0] USE_ENABLE = 2'b11,
   parameter logic [1:0] USE_ARESET = 2'b11,
   parameter logic [1:0] USE_PFD    = 2'b11,
   parameter logic [1:0] DIFF_REF   = 2'b00,
   parameter logic [1:0] EXT_USED   = 2'b11
) (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [1:0] loop_enable_i,
   input  wire logic [1:0] loop_areset_i,
   input  wire logic [1:0] pfd_enable_i,
   input  wire logic [3:0] feedback_mode_i,
   input  wire logic       ref_pin_pos_first_i,
   input  wire logic       ref_pin_neg_first_i,
   input  wire logic       ref_pin_pos_second_i,
   input  wire logic       ref_pin_neg_second_i,
   input  wire logic [3:0] gpio_out_i,
   input  wire logic [3:0] gpio_oe_i,
   output logic [1:0]      internal_clock_out_first_o,
   output logic [1:0]      internal_clock_out_second_o,
   output logic [1:0]      locked_o,
   output logic            first_ext_clock_pin_pos_o,
   output logic            first_ext_clock_pin_pos_oe_o,
   output logic            first_ext_clock_pin_neg_o,
   output logic            first_ext_clock_pin_neg_oe_o,
   output logic            second_ext_clock_pin_pos_o,
   output logic            second_ext_clock_pin_pos_oe_o,
   output logic            second_ext_clock_pin_neg_o,
   output logic            second_ext_clock_pin_neg_oe_o
);

   pllctl_pkg::pllctl_loop_s [1:0] q;
   pllctl_pkg::pllctl_loop_s [1:0] next_q;

   logic [1:0]      div_clear;
   logic [1:0]      div_load;
   logic [1:0]      div_tick;
   logic [1:0][2:0] div_lvl;
   logic [1:0]      ref_pos;
   logic [1:0]      ref_neg;

   // Alignment offset of a post-scale counter for the selected feedback mode.
   function automatic logic [pllctl_pkg::DIV_W-1:0] mode_offset(
      input pllctl_pkg::pllctl_fb_e mode,
      input logic                   is_ext
   );
      logic [pllctl_pkg::DIV_W-1:0] r;
      r = pllctl_pkg::ZERO_OFS;
      unique case (mode)
         pllctl_pkg::PLLCTL_FB_NORMAL: begin
            r = is_ext ? pllctl_pkg::SKEW_OFS : pllctl_pkg::ZERO_OFS; // R17 R18
         end
         pllctl_pkg::PLLCTL_FB_ZDB: begin
            r = is_ext ? pllctl_pkg::ZERO_OFS : pllctl_pkg::SKEW_OFS; // R19
         end
         pllctl_pkg::PLLCTL_FB_NOCOMP: begin
            r = pllctl_pkg::NOCOMP_OFS; // R20
         end
         default: begin
            // The spare code has no external feedback; it behaves as normal mode.
            r = is_ext ? pllctl_pkg::SKEW_OFS : pllctl_pkg::ZERO_OFS; // R15
         end
      endcase
      return r;
   endfunction

   // First pin pair is the first loop's reference, second pair the second's.
   assign ref_pos = {ref_pin_pos_second_i, ref_pin_pos_first_i}; // R22
   assign ref_neg = {ref_pin_neg_second_i, ref_pin_neg_first_i}; // R22

   for (genvar l = 0; l < 2; l++) begin : g_loop
      pllctl_pkg::pllctl_fb_e mode;
      assign mode = pllctl_pkg::pllctl_fb_e'(feedback_mode_i[2*l +: 2]);

      // Every counter keeps its own ratio, duty and phase in every mode.
      pllctl_postdiv u_g0 ( // R16
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .clear_i   (div_clear[l]),
         .load_i    (div_load[l]),
         .tick_i    (div_tick[l]),
         .delay_i   (mode_offset(mode, 1'b0) + pllctl_pkg::PH_G0),
         .high_i    (pllctl_pkg::G0_HIGH),
         .low_i     (pllctl_pkg::G0_LOW),
         .level_o   (div_lvl[l][0])
      );

      pllctl_postdiv u_g1 (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .clear_i   (div_clear[l]),
         .load_i    (div_load[l]),
         .tick_i    (div_tick[l]),
         .delay_i   (mode_offset(mode, 1'b0) + pllctl_pkg::PH_G1),
         .high_i    (pllctl_pkg::G1_HIGH),
         .low_i     (pllctl_pkg::G1_LOW),
         .level_o   (div_lvl[l][1])
      );

      pllctl_postdiv u_e (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .clear_i   (div_clear[l]),
         .load_i    (div_load[l]),
         .tick_i    (div_tick[l]),
         .delay_i   (mode_offset(mode, 1'b1) + pllctl_pkg::PH_E),
         .high_i    (pllctl_pkg::E_HIGH),
         .low_i     (pllctl_pkg::E_LOW),
         .level_o   (div_lvl[l][2])
      );
   end

   always_comb begin
      logic [1:0] en;
      logic [1:0] ar;
      logic [1:0] pf;
      logic [1:0] refin;
      logic [1:0] ref_edge;
      logic [1:0] run_ok;
      en        = '0;
      ar        = '0;
      pf        = '0;
      refin     = '0;
      ref_edge  = '0;
      run_ok    = '0;
      next_q    = q;
      div_clear = '0;
      div_load  = '0;
      div_tick  = '0;
      for (int l = 0; l < 2; l++) begin
         // The enable, reset, detector and reference pins are synchronised before use.
         next_q[l].ena_s = {q[l].ena_s[0], loop_enable_i[l]}; // R03
         next_q[l].rst_s = {q[l].rst_s[0], loop_areset_i[l]};
         next_q[l].pfd_s = {q[l].pfd_s[0], pfd_enable_i[l]};
         next_q[l].rp_s  = {q[l].rp_s[0], ref_pos[l]};
         next_q[l].rn_s  = {q[l].rn_s[0], ref_neg[l]};

         en[l] = USE_ENABLE[l] ? q[l].ena_s[1] : 1'b1; // R04
         ar[l] = USE_ARESET[l] ? q[l].rst_s[1] : 1'b0; // R08
         pf[l] = USE_PFD[l] ? q[l].pfd_s[1] : 1'b1;    // R12
         refin[l] = DIFF_REF[l] ? (q[l].rp_s[1] & ~q[l].rn_s[1]) : q[l].rp_s[1];
         ref_edge[l] = refin[l] & ~q[l].ref_prev;
         next_q[l].ref_prev = refin[l];
         run_ok[l] = en[l] & ~ar[l];

         if (!run_ok[l]) begin
            // Counters cleared, oscillator back to nominal, lock dropped.
            next_q[l].st      = pllctl_pkg::PLLCTL_OFF; // R01 R05 R24
            next_q[l].half    = pllctl_pkg::OSC_NOMINAL_HALF;
            next_q[l].osc_cnt = pllctl_pkg::OSC_CNT_ZERO;
            next_q[l].osc     = 1'b0;
            next_q[l].edges   = '0;
            next_q[l].refdiv  = '0;
            next_q[l].run     = '0;
            next_q[l].drift   = '0;
            next_q[l].resync  = 1'b1; // R02 R06
            div_clear[l]      = 1'b1;
         end else begin
            // The oscillator runs on its own, with or without a reference.
            if (q[l].osc_cnt + pllctl_pkg::OSC_STEP >= q[l].half) begin // R10
               next_q[l].osc_cnt = pllctl_pkg::OSC_CNT_ZERO;
               next_q[l].osc     = ~q[l].osc;
               div_tick[l]       = ~q[l].osc;
            end else begin
               next_q[l].osc_cnt = q[l].osc_cnt + pllctl_pkg::OSC_STEP;
            end
            if (div_tick[l] && q[l].edges != pllctl_pkg::EDGE_MAX) begin
               next_q[l].edges = q[l].edges + pllctl_pkg::EDGE_ONE;
            end

            if (q[l].st == pllctl_pkg::PLLCTL_OFF) begin
               // Starting from the fast nominal setting, output begins high.
               next_q[l].st     = pllctl_pkg::PLLCTL_ACQ; // R07
               next_q[l].half   = pllctl_pkg::OSC_NOMINAL_HALF;
               next_q[l].resync = 1'b1;
            end else if (pf[l]) begin
               next_q[l].drift = '0;
               if (q[l].st == pllctl_pkg::PLLCTL_HOLD) begin
                  next_q[l].st = pllctl_pkg::PLLCTL_ACQ; // R11
               end
               if (ref_edge[l]) begin
                  if (q[l].resync) begin
                     // Restart the output counters on a reference edge.
                     div_load[l]       = 1'b1; // R02 R06 R11
                     next_q[l].resync  = 1'b0;
                     next_q[l].edges   = '0;
                     next_q[l].refdiv  = '0;
                     next_q[l].osc_cnt = pllctl_pkg::OSC_CNT_ZERO;
                     next_q[l].osc     = 1'b0;
                  end else if (q[l].refdiv + pllctl_pkg::DIV_ONE >= pllctl_pkg::REF_DIV) begin
                     next_q[l].refdiv = '0;
                     next_q[l].edges  = div_tick[l] ? pllctl_pkg::EDGE_ONE : '0;
                     if (q[l].edges == pllctl_pkg::FB_MULT) begin
                        // Lock is only claimed after a run of matching windows.
                        if (q[l].run == pllctl_pkg::LOCK_RUN_LAST) begin
                           next_q[l].st = pllctl_pkg::PLLCTL_LOCK; // R13
                        end else begin
                           next_q[l].run = q[l].run + pllctl_pkg::RUN_ONE;
                        end
                     end else begin
                        // One mismatch drops lock, so the flag may toggle early on.
                        next_q[l].run = '0; // R14
                        next_q[l].st  = pllctl_pkg::PLLCTL_ACQ;
                        if (q[l].edges < pllctl_pkg::FB_MULT) begin
                           if (q[l].half > pllctl_pkg::OSC_MIN_HALF) begin
                              next_q[l].half = q[l].half - pllctl_pkg::OSC_STEP;
                           end
                        end else if (q[l].half < pllctl_pkg::OSC_MAX_HALF) begin
                           next_q[l].half = q[l].half + pllctl_pkg::OSC_STEP;
                        end
                     end
                  end else begin
                     next_q[l].refdiv = q[l].refdiv + pllctl_pkg::DIV_ONE;
                  end
               end
            end else begin
               // Detector gated: frequency held, creeping lower step by step.
               next_q[l].st     = pllctl_pkg::PLLCTL_HOLD; // R09
               next_q[l].run    = '0;
               next_q[l].resync = 1'b1;
               if (q[l].drift == pllctl_pkg::DRIFT_LAST) begin
                  next_q[l].drift = '0;
                  if (q[l].half < pllctl_pkg::OSC_MAX_HALF) begin
                     next_q[l].half = q[l].half + pllctl_pkg::OSC_STEP; // R09
                  end
               end else begin
                  next_q[l].drift = q[l].drift + pllctl_pkg::DRIFT_ONE;
               end
            end
         end

         next_q[l].out0   = run_ok[l] & div_lvl[l][0]; // R01
         next_q[l].out1   = run_ok[l] & div_lvl[l][1]; // R01
         next_q[l].locked = run_ok[l] && next_q[l].st == pllctl_pkg::PLLCTL_LOCK; // R24
         if (EXT_USED[l]) begin
            // The external counter reaches the pin pair and nothing else.
            next_q[l].ext_p    = run_ok[l] & div_lvl[l][2];  // R21 R23
            next_q[l].ext_n    = run_ok[l] & ~div_lvl[l][2]; // R21
            next_q[l].ext_p_oe = 1'b1;
            next_q[l].ext_n_oe = 1'b1;
         end else begin
            next_q[l].ext_p    = gpio_out_i[2*l];     // R21
            next_q[l].ext_n    = gpio_out_i[2*l + 1];
            next_q[l].ext_p_oe = gpio_oe_i[2*l];
            next_q[l].ext_n_oe = gpio_oe_i[2*l + 1];
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign internal_clock_out_first_o    = {q[1].out0, q[0].out0};
   assign internal_clock_out_second_o   = {q[1].out1, q[0].out1};
   assign locked_o                      = {q[1].locked, q[0].locked};
   assign first_ext_clock_pin_pos_o     = q[0].ext_p;
   assign first_ext_clock_pin_pos_oe_o  = q[0].ext_p_oe;
   assign first_ext_clock_pin_neg_o     = q[0].ext_n;
   assign first_ext_clock_pin_neg_oe_o  = q[0].ext_n_oe;
   assign second_ext_clock_pin_pos_o    = q[1].ext_p;
   assign second_ext_clock_pin_pos_oe_o = q[1].ext_p_oe;
   assign second_ext_clock_pin_neg_o    = q[1].ext_n;
   assign second_ext_clock_pin_neg_oe_o = q[1].ext_n_oe;

endmodule
`default_nettype wire

/* File: tb/pllctl_ref_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pllctl_ref_src #(
   parameter int HALF = 8
) (
   input  wire logic       clk_i,
   input  wire logic [1:0] run_i,
   output logic            ref_pin_pos_first_o,
   output logic            ref_pin_neg_first_o,
   output logic            ref_pin_pos_second_o,
   output logic            ref_pin_neg_second_o
);
   int         cnt = 0;
   logic [1:0] lvl = 2'b00;

   // A stopped source parks low, so the loop sees no edges rather than a held phase.
   always @(negedge clk_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      for (int l = 0; l < 2; l++) begin
         if (!run_i[l]) begin
            lvl[l] <= 1'b0;
         end else if (cnt == 0) begin
            lvl[l] <= ~lvl[l];
         end
      end
   end
   assign ref_pin_pos_first_o  = lvl[0];
   assign ref_pin_neg_first_o  = ~lvl[0];
   assign ref_pin_pos_second_o = lvl[1];
   assign ref_pin_neg_second_o = ~lvl[1];
endmodule
`default_nettype wire

/* File: tb/pllctl_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pllctl_top_assertions (
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   input wire logic [1:0] loop_enable_i,
   input wire logic [1:0] loop_areset_i,
   input wire logic [1:0] pfd_enable_i,
   input wire logic [1:0] internal_clock_out_first_o,
   input wire logic [1:0] internal_clock_out_second_o,
   input wire logic [1:0] locked_o,
   input wire logic       first_ext_clock_pin_pos_o,
   input wire logic       first_ext_clock_pin_neg_o,
   input wire logic       first_ext_clock_pin_pos_oe_o,
   input wire logic       second_ext_clock_pin_pos_o,
   input wire logic       second_ext_clock_pin_neg_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Two sync flops and the output flop: five samples cover the latency.
   chk_dis_clk_low: assert property (
      (!loop_enable_i[0])[*5] |-> !internal_clock_out_first_o[0]
         && !internal_clock_out_second_o[0] && !first_ext_clock_pin_pos_o
         && !first_ext_clock_pin_neg_o)
      else $error("loop 0 clock active while disabled");
   chk_rst_clear: assert property (
      loop_areset_i[1][*5] |-> !internal_clock_out_first_o[1] && !locked_o[1]
         && !internal_clock_out_second_o[1] && !second_ext_clock_pin_pos_o
         && !second_ext_clock_pin_neg_o)
      else $error("loop 1 outputs active in reset");
   chk_pfd_unlock: assert property (
      (!pfd_enable_i[0])[*5] |-> !locked_o[0])
      else $error("lock held with detector gated");
   chk_pfd_toggle: assert property (
      $fell(locked_o[0]) && loop_enable_i[0] && !loop_areset_i[0]
         |-> ##[1:64] $changed(internal_clock_out_first_o[0]))
      else $error("clock stopped after lock loss");
   chk_lock0_cause: assert property (
      locked_o[0] |-> $past(loop_enable_i[0], 4) && !$past(loop_areset_i[0], 4))
      else $error("loop 0 lock without enable");
   chk_lock1_cause: assert property (
      locked_o[1] |-> $past(loop_enable_i[1], 4) && !$past(loop_areset_i[1], 4))
      else $error("loop 1 lock without enable");
   chk_ext_compl: assert property (
      locked_o == 2'b11 |-> first_ext_clock_pin_neg_o != first_ext_clock_pin_pos_o
         && second_ext_clock_pin_neg_o != second_ext_clock_pin_pos_o)
      else $error("external pin pair not complementary");
   chk_ext_oe: assert property (
      !$past(sys_rst_i) |-> first_ext_clock_pin_pos_oe_o)
      else $error("external pin not driven");

   cover property ($rose(locked_o[0]));
   cover property ($rose(locked_o[1]));
   cover property (!pfd_enable_i[0] && internal_clock_out_first_o[0]);
endmodule

bind pllctl_top pllctl_top_assertions u_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .loop_enable_i(loop_enable_i),
   .loop_areset_i(loop_areset_i), .pfd_enable_i(pfd_enable_i), .locked_o(locked_o),
   .internal_clock_out_first_o(internal_clock_out_first_o),
   .internal_clock_out_second_o(internal_clock_out_second_o),
   .first_ext_clock_pin_pos_o(first_ext_clock_pin_pos_o),
   .first_ext_clock_pin_neg_o(first_ext_clock_pin_neg_o),
   .first_ext_clock_pin_pos_oe_o(first_ext_clock_pin_pos_oe_o),
   .second_ext_clock_pin_pos_o(second_ext_clock_pin_pos_o),
   .second_ext_clock_pin_neg_o(second_ext_clock_pin_neg_o));
`default_nettype wire

/* File: tb/pllctl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pllctl_top_tb;
   localparam int REF_HALF = 8;
   // Locked period of the first internal clock in system clocks.
   localparam int G0_PER = 2 * REF_HALF * int'(pllctl_pkg::REF_DIV)
      * (int'(pllctl_pkg::G0_HIGH) + int'(pllctl_pkg::G0_LOW)) / int'(pllctl_pkg::FB_MULT);
   logic       clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [1:0] en = 2'b00;
   logic [1:0] ars = 2'b00;
   logic [1:0] phase_frequency_detector = 2'b11;
   logic [1:0] run = 2'b11;
   logic [3:0] mode = 4'h0;
   logic [3:0] gp_out = 4'h5;
   logic [3:0] gp_oe = 4'ha;
   wire        rp0, rn0, rp1, rn1;
   logic [1:0] ck0, ck1, lk;
   logic       e1p, e1n, e2p, e2n, o1p, o1n, o2p, o2n;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         per;

   always #10 clk_i = ~clk_i;

   pllctl_ref_src #(.HALF(REF_HALF)) u_ref (
      .clk_i(clk_i), .run_i(run), .ref_pin_pos_first_o(rp0), .ref_pin_neg_first_o(rn0),
      .ref_pin_pos_second_o(rp1), .ref_pin_neg_second_o(rn1));

   pllctl_top DUT (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .loop_enable_i(en), .loop_areset_i(ars),
      .pfd_enable_i(phase_frequency_detector), .feedback_mode_i(mode), .ref_pin_pos_first_i(rp0),
      .ref_pin_neg_first_i(rn0), .ref_pin_pos_second_i(rp1), .ref_pin_neg_second_i(rn1),
      .gpio_out_i(gp_out), .gpio_oe_i(gp_oe), .internal_clock_out_first_o(ck0),
      .internal_clock_out_second_o(ck1), .locked_o(lk), .first_ext_clock_pin_pos_o(e1p),
      .first_ext_clock_pin_pos_oe_o(o1p), .first_ext_clock_pin_neg_o(e1n),
      .first_ext_clock_pin_neg_oe_o(o1n), .second_ext_clock_pin_pos_o(e2p),
      .second_ext_clock_pin_pos_oe_o(o2p), .second_ext_clock_pin_neg_o(e2n),
      .second_ext_clock_pin_neg_oe_o(o2n));

   task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_count(input int got, input int exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, n_mismatch);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic wait_lock(input int l);
      int   run_len;
      logic got;
      run_len = 0;
      got = 1'b0;
      for (int t = 0; t < 3000 && !got; t++) begin
         @(negedge clk_i);
         run_len = (lk[l] === 1'b1) ? run_len + 1 : 0;
         // Lock may chatter while tracking starts, so only a steady run counts.
         got = run_len >= 16;
      end
      check_bits({7'h0, got}, 8'h01);
   endtask

   task automatic wait_ck0(input logic v, inout int n);
      for (int t = 0; t < 400 && ck0[0] !== v; t++) begin
         @(negedge clk_i);
         n++;
      end
   endtask

   task automatic g0_period(output int p);
      int n;
      n = 0;
      wait_ck0(1'b0, n);
      wait_ck0(1'b1, n);
      n = 0;
      wait_ck0(1'b0, n);
      wait_ck0(1'b1, n);
      p = n;
   endtask

   task automatic test_reset;
      cycles(10);
      check_bits({ck0, ck1, lk, e1p, e1n}, 8'h00);
      check_bits({4'h0, o1p, o1n, o2p, o2n}, 8'h0f);
      end_test("reset");
   endtask

   task automatic test_lock;
      en = 2'b11;
      wait_lock(0);
      wait_lock(1);
      check_bits({6'h0, e1n, e2n}, {6'h0, ~e1p, ~e2p});
      g0_period(per);
      check_count(per, G0_PER);
      end_test("lock");
   endtask

   task automatic test_enable;
      en[0] = 1'b0;
      cycles(6);
      check_bits({ck0[0], ck1[0], lk[0], e1p, e1n, lk[1], 2'b00}, 8'h04);
      en[0] = 1'b1;
      wait_lock(0);
      end_test("enable");
   endtask

   task automatic test_areset;
      ars = 2'b11;
      cycles(6);
      check_bits({ck0, ck1, lk, e1p, e2p}, 8'h00);
      ars = 2'b00;
      g0_period(per);
      check_bits({7'h0, per < G0_PER}, 8'h01);
      wait_lock(0);
      wait_lock(1);
      end_test("areset");
   endtask

   task automatic test_pfd;
      phase_frequency_detector[0] = 1'b0;
      run[0] = 1'b0;
      cycles(6);
      check_bits({7'h0, lk[0]}, 8'h00);
      cycles(pllctl_pkg::DRIFT_STEP_CYC + 50);
      g0_period(per);
      check_bits({6'h0, per > G0_PER, per < 40}, 8'h03);
      check_bits({7'h0, lk[1]}, 8'h01);
      run[0] = 1'b1;
      phase_frequency_detector[0] = 1'b1;
      wait_lock(0);
      end_test("pfd");
   endtask

   task automatic test_modes;
      logic [1:0] codes [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
      for (int i = 0; i < 4; i++) begin
         mode = {codes[i], codes[i]};
         ars = 2'b11;
         cycles(6);
         ars = 2'b00;
         wait_lock(0);
         g0_period(per);
         check_count(per, G0_PER);
         check_bits({7'h0, e1p === ck0[0]}, {7'h0, codes[i] == 2'b11});
         check_bits({6'h0, e1n, e2n}, {6'h0, ~e1p, ~e2p});
      end
      end_test("modes");
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      test_reset();
      test_lock();
      test_enable();
      test_areset();
      test_pfd();
      test_modes();
      print_verdict();
   end

   // The whole run needs under 4k cycles; 20k means a loop never locked.
   initial begin
      #400_000;
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
